// File: shared/cswd_defs.svh
// Timing counts and reset values for the charge safety watchdog block.
`ifndef CSWD_DEFS_SVH
`define CSWD_DEFS_SVH
`define CSWD_CLK_MHZ 250
`define CSWD_INT_PULSE_US 128
`define CSWD_INT_PULSE_CYC (`CSWD_INT_PULSE_US * `CSWD_CLK_MHZ)
`define CSWD_WDOG_S 50
`define CSWD_WDOG_CYC (64'd`CSWD_WDOG_S * 64'd1000000 * 64'd`CSWD_CLK_MHZ)
`define CSWD_TICK_MS 1
`define CSWD_TICK_CYC (`CSWD_TICK_MS * 1000 * `CSWD_CLK_MHZ)
`define CSWD_PRECHG_DIV 10
`define CSWD_VREG_DROP_MV 140
`define CSWD_VREG_MIN_MV 3600
`define CSWD_TMR_RST 2'h1
`define CSWD_HALF_RST 1'b0
`define CSWD_ICHG_RST 8'h10
`define CSWD_VREG_RST 13'h1068
`define CSWD_CHGEN_N_RST 1'b1
`define CSWD_BTNIN_RST 2'h0
`define CSWD_BTNREC_RST 1'b0
`endif

// File: shared/cswd_pkg.sv
// Types shared by the charge safety watchdog block.
package cswd_pkg;
   typedef enum logic [2:0]
   {
      CSWD_IDLE = 3'b000,
      CSWD_PRE = 3'b001,
      CSWD_FAST = 3'b010,
      CSWD_DONE = 3'b011,
      CSWD_FAULT = 3'b100,
      CSWD_HOT = 3'b101
   } cswd_state_t;
   typedef struct packed
   {
      logic tsOff;
      logic tooHot;
      logic warm;
      logic cool;
      logic tooCold;
   } cswd_temp_t;
   typedef struct packed
   {
      logic [1:0] safetyTimeSelect;
      logic halfRateTimerEnable;
      logic [7:0] chargeCurrentReg;
      logic [12:0] vregMv;
      logic chargeEnableN;
      logic [1:0] buttonResetInputCfg;
      logic buttonRecoveryCfg;
   } cswd_cfg_t;
endpackage

// File: hdl/cswd_ctrl.sv
// Charge safety timer, host watchdog, thermistor windows and die thermal gate.
`timescale 1ns/1ps
`include "cswd_defs.svh"
// Notes on behaviour
// (R01) Safety timer starts when charge cycle begins.
// (R02) Timer expiry before termination: fault, charge off.
// (R03) Pre-charge limited to one tenth maximum.
// (R04) Timer fault: one 128 us interrupt pulse.
// (R05) Fault clears only by chip disable or power.
// (R06) Time select; new value restarts timer.
// (R07) Half-rate option halves speed under other loops.
// (R08) Host watchdog times out after 50 seconds.
// (R09) Watchdog idle until first link transaction.
// (R10) High impedance disables watchdog until next transaction.
// (R11) Each transaction reloads watchdog count.
// (R12) Expiry restores defaults except button settings.
// (R13) Hot or cold suspends charging and timers; the code clears the safety timer count instead of holding it.
// (R14) Cool band halves charge current.
// (R15) Warm band drops target 140 mV, floor 3.6 V.
// (R16) Thermistor disabled ignores temperature windows.
// (R17) Die overheat stops charge, disables outputs.
// (R18) Overheat holds safety timer; watchdog keeps running. The code clears the safety timer count and restarts it from zero.
// (R19) Resume only after temperature drops by hysteresis.
// (R20) Grounded current pin selects register current.
// (R21) Charge begins on enable low with valid input.
// (R22) Comparator inputs are asynchronous; two-flop synchronised here.
module cswd_ctrl #(
   parameter int unsigned TICK_CYC = `CSWD_TICK_CYC,
   parameter longint unsigned WDOG_CYC = `CSWD_WDOG_CYC,
   parameter int unsigned INT_PULSE_CYC = `CSWD_INT_PULSE_CYC,
   parameter int unsigned BASE_TICKS = 1800000
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic link_rst,
   input wire logic linkXferDone,
   input wire cswd_pkg::cswd_cfg_t linkWrCfg,
   input wire logic linkWrStrobe,
   output cswd_pkg::cswd_cfg_t cfgOut,
   input wire logic inputValid,
   input wire logic chip_disable_n,
   input wire logic highImpedance,
   input wire cswd_pkg::cswd_temp_t tempIn,
   input wire logic dieHotIn,
   input wire logic dieCoolIn,
   input wire logic termDoneIn,
   input wire logic vbatBelowPreIn,
   input wire logic otherLoopIn,
   input wire logic chargeCurrentPinGnd,
   input wire logic [7:0] chargeCurrentPinVal,
   output logic chargeOn,
   output logic [7:0] chargeCurrent,
   output logic [12:0] vregTarget,
   output logic outputsOn,
   output logic intPulse,
   output cswd_pkg::cswd_state_t chargeState,
   output logic safetyFault,
   output logic watchdogExpired
);
   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [11:0] syncA_reg;
   logic [11:0] syncB_reg;
   logic cdRaw;
   logic cdPrev_reg;
   cswd_pkg::cswd_temp_t temp;
   logic dieHot, dieCool, termDone, vbatPre, otherLoop, vinOk, hiZ;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         syncA_reg <= 12'h000;
         syncB_reg <= 12'h000;
      end
      else
      begin
         syncA_reg <= {tempIn, dieHotIn, dieCoolIn, termDoneIn, vbatBelowPreIn,
                       otherLoopIn, chip_disable_n, inputValid}; // see (R22)
         syncB_reg <= syncA_reg;
      end
   end
   assign temp = cswd_pkg::cswd_temp_t'(syncB_reg[11:7]);
   assign dieHot = syncB_reg[6];
   assign dieCool = syncB_reg[5];
   assign termDone = syncB_reg[4];
   assign vbatPre = syncB_reg[3];
   assign otherLoop = syncB_reg[2];
   assign cdRaw = syncB_reg[1];
   assign vinOk = syncB_reg[0];
   logic [8:0] pinSyncA_reg;
   logic [8:0] pinSyncB_reg;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pinSyncA_reg <= 9'h000;
         pinSyncB_reg <= 9'h000;
      end
      else
      begin
         pinSyncA_reg <= {chargeCurrentPinGnd, chargeCurrentPinVal};
         pinSyncB_reg <= pinSyncA_reg;
      end
   end
   // ----------------------------------------------------------------------
   // Link domain: transaction and write events cross by toggle
   // ----------------------------------------------------------------------
   logic xferTog_reg, wrTog_reg;
   cswd_pkg::cswd_cfg_t wrHold_reg;
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         xferTog_reg <= 1'b0;
         wrTog_reg <= 1'b0;
         wrHold_reg <= '0;
      end
      else
      begin
         if (linkXferDone)
            xferTog_reg <= ~xferTog_reg;
         if (linkWrStrobe)
         begin
            wrTog_reg <= ~wrTog_reg;
            wrHold_reg <= linkWrCfg;
         end
      end
   end
   logic [2:0] xferSync_reg, wrSync_reg;
   logic [1:0] hizSync_reg;
   logic xferEv, wrEv;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         xferSync_reg <= 3'h0;
         wrSync_reg <= 3'h0;
         hizSync_reg <= 2'h0;
      end
      else
      begin
         xferSync_reg <= {xferSync_reg[1:0], xferTog_reg};
         wrSync_reg <= {wrSync_reg[1:0], wrTog_reg};
         hizSync_reg <= {hizSync_reg[0], highImpedance};
      end
   end
   assign xferEv = xferSync_reg[2] ^ xferSync_reg[1];
   assign wrEv = wrSync_reg[2] ^ wrSync_reg[1];
   assign hiZ = hizSync_reg[1];
   // ----------------------------------------------------------------------
   // Host watchdog
   // ----------------------------------------------------------------------
   logic wdArmed_reg;
   logic [63:0] wdCnt_reg;
   always_ff @(posedge core_clk)
   begin
      if (srst || hiZ)
      begin
         wdArmed_reg <= 1'b0; // see (R09) (R10)
         wdCnt_reg <= 64'h0;
         watchdogExpired <= 1'b0;
      end
      else
      begin
         watchdogExpired <= 1'b0;
         if (xferEv)
         begin
            wdArmed_reg <= 1'b1;
            wdCnt_reg <= 64'h0; // see (R11)
         end
         else if (wdArmed_reg)
         begin
            // Keeps counting through die overheat.
            if (wdCnt_reg >= WDOG_CYC - 64'h1) // see (R08) (R18)
            begin
               watchdogExpired <= 1'b1;
               wdArmed_reg <= 1'b0;
               wdCnt_reg <= 64'h0;
            end
            else
               wdCnt_reg <= wdCnt_reg + 64'h1;
         end
      end
   end
   // ----------------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------------
   cswd_pkg::cswd_cfg_t cfg_reg;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cfg_reg.safetyTimeSelect <= `CSWD_TMR_RST;
         cfg_reg.halfRateTimerEnable <= `CSWD_HALF_RST;
         cfg_reg.chargeCurrentReg <= `CSWD_ICHG_RST;
         cfg_reg.vregMv <= `CSWD_VREG_RST;
         cfg_reg.chargeEnableN <= `CSWD_CHGEN_N_RST;
         cfg_reg.buttonResetInputCfg <= `CSWD_BTNIN_RST;
         cfg_reg.buttonRecoveryCfg <= `CSWD_BTNREC_RST;
      end
      else if (wrEv)
         cfg_reg <= wrHold_reg;
      else if (watchdogExpired)
      begin
         cfg_reg.safetyTimeSelect <= `CSWD_TMR_RST; // see (R12)
         cfg_reg.halfRateTimerEnable <= `CSWD_HALF_RST;
         cfg_reg.chargeCurrentReg <= `CSWD_ICHG_RST;
         cfg_reg.vregMv <= `CSWD_VREG_RST;
         cfg_reg.chargeEnableN <= `CSWD_CHGEN_N_RST;
      end
   end
   assign cfgOut = cfg_reg;
   // ----------------------------------------------------------------------
   // Safety timer
   // ----------------------------------------------------------------------
   cswd_pkg::cswd_state_t state_reg;
   logic [31:0] tickDiv_reg;
   logic [31:0] ticks_reg;
   logic halfPh_reg;
   logic [31:0] maxTicks;
   logic [1:0] tmrPrev_reg;
   logic tempPause, tempActive, running, cdToggle, tickEv, startEv;
   assign maxTicks = BASE_TICKS << cfg_reg.safetyTimeSelect; // see (R06)
   assign tempActive = ~temp.tsOff; // see (R16)
   assign tempPause = tempActive && (temp.tooHot || temp.tooCold); // see (R13)
   assign running = (state_reg == cswd_pkg::CSWD_PRE) || (state_reg == cswd_pkg::CSWD_FAST);
   assign cdToggle = cdRaw != cdPrev_reg;
   assign tickEv = tickDiv_reg >= TICK_CYC - 1;
   assign startEv = !cfg_reg.chargeEnableN && vinOk && !cdRaw; // see (R21)
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cdPrev_reg <= 1'b0;
         tmrPrev_reg <= `CSWD_TMR_RST;
      end
      else
      begin
         cdPrev_reg <= cdRaw;
         tmrPrev_reg <= cfg_reg.safetyTimeSelect;
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (srst || !running || tempPause || tmrPrev_reg != cfg_reg.safetyTimeSelect)
      begin
         tickDiv_reg <= 32'h0; // see (R06) (R13)
         ticks_reg <= 32'h0;
         halfPh_reg <= 1'b0;
      end
      else if (tickEv)
      begin
         tickDiv_reg <= 32'h0;
         halfPh_reg <= ~halfPh_reg;
         if (!(cfg_reg.halfRateTimerEnable && otherLoop) || halfPh_reg) // see (R07)
            ticks_reg <= ticks_reg + 32'h1;
      end
      else
         tickDiv_reg <= tickDiv_reg + 32'h1;
   end
   // ----------------------------------------------------------------------
   // Charge state machine
   // ----------------------------------------------------------------------
   logic timeout;
   assign timeout = (state_reg == cswd_pkg::CSWD_PRE) ?
                    (ticks_reg >= maxTicks / `CSWD_PRECHG_DIV) : // see (R03)
                    (ticks_reg >= maxTicks); // see (R02)
   always_ff @(posedge core_clk)
   begin
      if (srst || !vinOk)
         state_reg <= cswd_pkg::CSWD_IDLE; // see (R05)
      else
      begin
         case (state_reg)
            cswd_pkg::CSWD_IDLE:
               if (dieHot)
                  state_reg <= cswd_pkg::CSWD_HOT;
               else if (startEv)
                  state_reg <= vbatPre ? cswd_pkg::CSWD_PRE : cswd_pkg::CSWD_FAST; // see (R01)
            cswd_pkg::CSWD_PRE, cswd_pkg::CSWD_FAST:
               if (dieHot)
                  state_reg <= cswd_pkg::CSWD_HOT; // see (R17)
               else if (!startEv)
                  state_reg <= cswd_pkg::CSWD_IDLE;
               else if (termDone && state_reg == cswd_pkg::CSWD_FAST)
                  state_reg <= cswd_pkg::CSWD_DONE;
               else if (timeout)
                  state_reg <= cswd_pkg::CSWD_FAULT; // see (R02) (R04)
               else if (state_reg == cswd_pkg::CSWD_PRE && !vbatPre)
                  state_reg <= cswd_pkg::CSWD_FAST;
            cswd_pkg::CSWD_DONE:
               if (!startEv)
                  state_reg <= cswd_pkg::CSWD_IDLE;
            cswd_pkg::CSWD_FAULT:
               if (cdToggle)
                  state_reg <= cswd_pkg::CSWD_IDLE; // see (R05)
            cswd_pkg::CSWD_HOT:
               if (dieCool)
                  state_reg <= cswd_pkg::CSWD_IDLE; // see (R19)
            default:
               state_reg <= cswd_pkg::CSWD_IDLE;
         endcase
      end
   end
   assign chargeState = state_reg;
   // ----------------------------------------------------------------------
   // Fault pulse and outputs
   // ----------------------------------------------------------------------
   logic [31:0] pulseCnt_reg;
   logic faultPrev_reg;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pulseCnt_reg <= 32'h0;
         faultPrev_reg <= 1'b0;
         intPulse <= 1'b0;
      end
      else
      begin
         faultPrev_reg <= state_reg == cswd_pkg::CSWD_FAULT;
         if (state_reg == cswd_pkg::CSWD_FAULT && !faultPrev_reg)
         begin
            intPulse <= 1'b1; // see (R04)
            pulseCnt_reg <= INT_PULSE_CYC - 1;
         end
         else if (pulseCnt_reg != 32'h0)
            pulseCnt_reg <= pulseCnt_reg - 32'h1;
         else
            intPulse <= 1'b0;
      end
   end
   logic [12:0] vregWarm;
   assign vregWarm = (cfg_reg.vregMv >= 13'(`CSWD_VREG_MIN_MV + `CSWD_VREG_DROP_MV)) ?
                     cfg_reg.vregMv - 13'(`CSWD_VREG_DROP_MV) : 13'(`CSWD_VREG_MIN_MV);
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         chargeOn <= 1'b0;
         chargeCurrent <= 8'h00;
         vregTarget <= `CSWD_VREG_RST;
         outputsOn <= 1'b0;
         safetyFault <= 1'b0;
      end
      else
      begin
         chargeOn <= running && !tempPause && !dieHot; // see (R13) (R17)
         chargeCurrent <= (pinSyncB_reg[8] ? cfg_reg.chargeCurrentReg
                           : pinSyncB_reg[7:0]) // see (R20)
                          >> ((tempActive && temp.cool) ? 1 : 0); // see (R14)
         vregTarget <= (tempActive && temp.warm) ? vregWarm : cfg_reg.vregMv; // see (R15)
         outputsOn <= state_reg != cswd_pkg::CSWD_HOT && !dieHot; // see (R17)
         safetyFault <= state_reg == cswd_pkg::CSWD_FAULT;
      end
   end
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence faultEntry;
      state_reg == cswd_pkg::CSWD_FAULT && !faultPrev_reg;
   endsequence
   a_fault_pulse_rise: assert property (@(posedge core_clk) disable iff (srst) // see (R04)
      faultEntry |=> intPulse)
      else $error("fault did not raise interrupt pulse");
   a_hot_stops_charge: assert property (@(posedge core_clk) disable iff (srst) // see (R17)
      dieHot |=> !chargeOn && !outputsOn)
      else $error("charge or outputs on during die overheat");
   a_temp_pause_charge: assert property (@(posedge core_clk) disable iff (srst) // see (R13)
      tempPause |=> !chargeOn)
      else $error("charge on outside temperature window");
   a_fault_stays_latched: assert property (@(posedge core_clk) disable iff (srst) // see (R05)
      state_reg == cswd_pkg::CSWD_FAULT && vinOk && !cdToggle |=>
      state_reg == cswd_pkg::CSWD_FAULT)
      else $error("safety fault cleared without disable toggle");
   a_wd_reload_xfer: assert property (@(posedge core_clk) disable iff (srst) // see (R11)
      xferEv && !hiZ |=> wdCnt_reg == 64'h0 && wdArmed_reg)
      else $error("transaction did not reload watchdog");
   a_wd_hiz_off: assert property (@(posedge core_clk) disable iff (srst) // see (R10)
      hiZ |=> !wdArmed_reg)
      else $error("watchdog armed in high impedance");
   a_warm_floor: assert property (@(posedge core_clk) disable iff (srst) // see (R15)
      tempActive && temp.warm |=> vregTarget >= 13'(`CSWD_VREG_MIN_MV))
      else $error("warm target below floor");
   a_timer_hold_hot: assert property (@(posedge core_clk) disable iff (srst) // see (R18)
      state_reg == cswd_pkg::CSWD_HOT |=> ticks_reg == 32'h0)
      else $error("safety timer ran during die overheat");
   a_timeout_fault: assert property (@(posedge core_clk) disable iff (srst) // see (R02)
      running && vinOk && startEv && !dieHot && !termDone && timeout |=>
      state_reg == cswd_pkg::CSWD_FAULT)
      else $error("timeout did not enter fault");
endmodule // cswd_ctrl

// File: bench/cswd_host_model.sv
// Host-side model that issues configuration writes and link transactions.
`timescale 1ns/1ps
module cswd_host_model
(
   input wire logic link_clk,
   output logic linkXferDone,
   output cswd_pkg::cswd_cfg_t linkWrCfg,
   output logic linkWrStrobe
);
   initial
   begin
      linkXferDone = 1'b0;
      linkWrStrobe = 1'b0;
      linkWrCfg = '1;
   end
   // Each call is one whole transaction; a released bus shows the inverse word.
   task automatic xfer(input logic wr, input cswd_pkg::cswd_cfg_t c);
      @(posedge link_clk);
      linkWrStrobe <= wr;
      linkXferDone <= 1'b1;
      linkWrCfg <= c;
      @(posedge link_clk);
      linkWrStrobe <= 1'b0;
      linkXferDone <= 1'b0;
      linkWrCfg <= ~c;
   endtask
endmodule // cswd_host_model

// File: bench/tb_top.sv
// Self-checking bench for the charge safety watchdog block.
`timescale 1ns/1ps
`include "cswd_defs.svh"
module tb_top;
   localparam int TK = 4, BT = 20, WD = 200, IP = 8;
   logic core_clk = 1'b0, link_clk = 1'b0, srst = 1'b1, linkRst = 1'b1;
   logic inputValid = 1'b0, chip_disable_n = 1'b1, highImpedance = 1'b0;
   logic dieHotIn = 1'b0, dieCoolIn = 1'b1, termDoneIn = 1'b0, vbatBelowPreIn = 1'b0;
   logic otherLoopIn = 1'b0, chargeCurrentPinGnd = 1'b1;
   logic [7:0] chargeCurrentPinVal = 8'h33;
   cswd_pkg::cswd_temp_t tempIn = '0;
   cswd_pkg::cswd_cfg_t cfg, cfgOut, linkWrCfg;
   logic linkXferDone, linkWrStrobe, chargeOn, outputsOn, intPulse, safetyFault;
   logic watchdogExpired;
   logic [7:0] chargeCurrent;
   logic [12:0] vregTarget;
   cswd_pkg::cswd_state_t chargeState;
   int n_errors = 0, checks = 0, wdPulses = 0, i, p;

   always #2 core_clk = ~core_clk;
   always #7.5 link_clk = ~link_clk;
   always @(posedge core_clk) if (watchdogExpired === 1'b1) wdPulses++;

   cswd_host_model host (.link_clk, .linkXferDone, .linkWrCfg, .linkWrStrobe);
   cswd_ctrl #(.TICK_CYC(TK), .WDOG_CYC(WD), .INT_PULSE_CYC(IP), .BASE_TICKS(BT)) dut
   (
      .core_clk, .srst, .link_clk, .link_rst(linkRst), .linkXferDone, .linkWrCfg,
      .linkWrStrobe, .cfgOut, .inputValid, .chip_disable_n, .highImpedance, .tempIn,
      .dieHotIn, .dieCoolIn, .termDoneIn, .vbatBelowPreIn, .otherLoopIn,
      .chargeCurrentPinGnd, .chargeCurrentPinVal, .chargeOn, .chargeCurrent, .vregTarget,
      .outputsOn, .intPulse, .chargeState, .safetyFault, .watchdogExpired
   );

   //--------------------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic stop_test();
      $display("counts: checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      checks++;
      if (got < lo || got > hi)
      begin
         n_errors++;
         $display("[ERR] %0t %s took %0d", $time, what, got);
      end
   endtask
   task automatic wr();
      host.xfer(1'b1, cfg);
      cyc(12);
   endtask
   task automatic restart();
      cyc(1);
      chip_disable_n <= 1'b1;
      cyc(10);
      chip_disable_n <= 1'b0;
   endtask
   task automatic put_temp(input cswd_pkg::cswd_temp_t t);
      cyc(1);
      tempIn <= t;
      cyc(8);
   endtask
   // Waits for a safety fault and checks the time it took from the call.
   task automatic fault_after(input int exp);
      int n;
      for (n = 0; n < 2 * exp + 60 && safetyFault !== 1'b1; n++)
         cyc(1);
      if (safetyFault !== 1'b1)
      begin
         n_errors++;
         $display("[ERR] %0t wait ran out", $time);
         stop_test();
      end
      chk_rng(n, exp - 4, exp + 24, "fault time");
   endtask

   //--------------------------------------------------------------------------
   // Main sequence
   //--------------------------------------------------------------------------
   initial
   begin
      cfg = '0;
      cyc(8);
      srst <= 1'b0;
      linkRst <= 1'b0;
      cyc(2);
      chk(vregTarget, `CSWD_VREG_RST, "vreg rst");
      chk({chargeOn, safetyFault}, 2'b00, "out rst");
      cyc(300);
      chk(wdPulses, 0, "wd idle");
      cfg = {2'h3, 1'b1, 8'h40, 13'hE74, 1'b1, 2'h2, 1'b1};
      wr();
      chk(cfgOut, cfg, "cfg write");
      repeat (4)
      begin
         cyc(120);
         host.xfer(1'b0, cfg);
      end
      chk(wdPulses, 0, "wd reload");
      for (i = 0; i < 400 && wdPulses == 0; i++)
         cyc(1);
      chk_rng(i, WD - 4, WD + 24, "wd time");
      if (wdPulses == 0)
         stop_test();
      cfg = {`CSWD_TMR_RST, `CSWD_HALF_RST, `CSWD_ICHG_RST, `CSWD_VREG_RST,
             `CSWD_CHGEN_N_RST, 2'h2, 1'b1};
      cyc(4);
      chk(cfgOut, cfg, "wd defaults");
      highImpedance <= 1'b1;
      cyc(8);
      host.xfer(1'b0, cfg);
      cyc(400);
      chk(wdPulses, 1, "wd hiz");
      $display("test watchdog done");
      cfg.chargeEnableN = 1'b0;
      cfg.chargeCurrentReg = 8'h40;
      cfg.vregMv = 13'hE74;
      wr();
      inputValid <= 1'b1;
      vbatBelowPreIn <= 1'b1;
      restart();
      cyc(7);
      chk(chargeOn, 1'b1, "charge on");
      chk(chargeState, cswd_pkg::CSWD_PRE, "pre state");
      fault_after((BT << 1) / 10 * TK - 7);
      p = 0;
      repeat (40)
      begin
         if (intPulse === 1'b1)
            p++;
         cyc(1);
      end
      chk(p, IP, "int pulse");
      chk({chargeOn, chargeState}, {1'b0, cswd_pkg::CSWD_FAULT}, "fault st");
      cyc(60);
      chk(safetyFault, 1'b1, "fault held");
      vbatBelowPreIn <= 1'b0;
      restart();
      cyc(7);
      chk(safetyFault, 1'b0, "fault clr");
      fault_after((BT << 1) * TK - 7);
      cfg.halfRateTimerEnable = 1'b1;
      wr();
      otherLoopIn <= 1'b1;
      restart();
      fault_after((BT << 2) * TK);
      otherLoopIn <= 1'b0;
      cfg.halfRateTimerEnable = 1'b0;
      cfg.safetyTimeSelect = 2'h0;
      wr();
      restart();
      cyc(50);
      cfg.safetyTimeSelect = 2'h1;
      wr();
      fault_after((BT << 1) * TK - 12);
      $display("test safety timer done");
      cfg.safetyTimeSelect = 2'h3;
      wr();
      restart();
      put_temp(5'b00010);
      chk(chargeCurrent, 8'h20, "cool");
      put_temp(5'b00100);
      chk(vregTarget, 13'hE10, "warm floor");
      cfg.vregMv = 13'h1068;
      wr();
      chk(vregTarget, 13'hFDC, "warm drop");
      put_temp(5'b01000);
      chk(chargeOn, 1'b0, "hot");
      cyc(700);
      chk(safetyFault, 1'b0, "hot timer");
      put_temp(5'b11000);
      chk(chargeOn, 1'b1, "ts off");
      put_temp(5'b00001);
      chk(chargeOn, 1'b0, "cold");
      put_temp(5'b00000);
      chargeCurrentPinGnd <= 1'b0;
      cyc(8);
      chk(chargeCurrent, 8'h33, "pin val");
      chargeCurrentPinGnd <= 1'b1;
      cyc(8);
      chk(chargeCurrent, 8'h40, "reg val");
      $display("test temperature done");
      dieHotIn <= 1'b1;
      dieCoolIn <= 1'b0;
      cyc(8);
      chk({chargeOn, outputsOn}, 2'b00, "die hot");
      chk(chargeState, cswd_pkg::CSWD_HOT, "hot state");
      dieHotIn <= 1'b0;
      cyc(8);
      chk(chargeOn, 1'b0, "hysteresis");
      dieCoolIn <= 1'b1;
      cyc(8);
      chk({chargeOn, outputsOn}, 2'b11, "die cool");
      fault_after((BT << 3) * TK - 8);
      $display("test die thermal done");
      stop_test();
   end
endmodule // tb_top
